// file: core/ctm_pkg.sv
// Purpose: shared constants and types of the compact timer core
// Assumes: one 32-bit register per aligned word, data in the low byte
// Notes:   clock select and mode encodings are the hardware ones
package timer_core_pkg;

  localparam int unsigned ADDR_W = 6;

  // word index of each register, byte address is four times the index
  localparam logic [3:0] IDX_CTRL0   = 4'h0;
  localparam logic [3:0] IDX_CTRL1   = 4'h1;
  localparam logic [3:0] IDX_CNT_LO  = 4'h2;
  localparam logic [3:0] IDX_CNT_HI  = 4'h3;
  localparam logic [3:0] IDX_CMPA_LO = 4'h4;
  localparam logic [3:0] IDX_CMPA_HI = 4'h5;
  localparam logic [3:0] IDX_CMPP    = 4'h6;
  localparam logic [3:0] IDX_STAT    = 4'h7;

  localparam int unsigned STAT_A_BIT = 0;
  localparam int unsigned STAT_P_BIT = 1;

  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] CMPA_RST = 16'h0000;
  localparam logic [7:0]  CMPP_RST = 8'h00;
  localparam logic [7:0]  BUF_RST  = 8'h00;

  localparam int unsigned SYS_DIV      = 4;
  localparam int unsigned HIGH_DIV_LO  = 16;
  localparam int unsigned HIGH_DIV_HI  = 64;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    CK_SYS_DIV4   = 3'h0,
    CK_SYS        = 3'h1,
    CK_HIGH_DIV16 = 3'h2,
    CK_HIGH_DIV64 = 3'h3,
    CK_SUB_A      = 3'h4,
    CK_SUB_B      = 3'h5,
    CK_EXT_RISE   = 3'h6,
    CK_EXT_FALL   = 3'h7
  } clk_sel_t;

  typedef enum logic [1:0] {
    MODE_CMP   = 2'h0,
    MODE_UNDEF = 2'h1,
    MODE_PWM   = 2'h2,
    MODE_TIMER = 2'h3
  } mode_t;

  // output action in compare match output mode
  localparam logic [1:0] IO_HOLD   = 2'h0;
  localparam logic [1:0] IO_LOW    = 2'h1;
  localparam logic [1:0] IO_HIGH   = 2'h2;
  localparam logic [1:0] IO_TOGGLE = 2'h3;
  // output action in pwm output mode
  localparam logic [1:0] PWM_INACTIVE = 2'h0;
  localparam logic [1:0] PWM_ACTIVE   = 2'h1;
  localparam logic [1:0] PWM_WAVE     = 2'h2;

  typedef struct packed {
    logic     pause;
    clk_sel_t clk_sel;
    logic     run;
  } ctrl0_t;

  typedef struct packed {
    mode_t      mode;
    logic [1:0] io;
    logic       oc;
    logic       pol;
    logic       dpx;
    logic       cclr;
  } ctrl1_t;

  localparam ctrl0_t CTRL0_RST = ctrl0_t'(5'h00);
  localparam ctrl1_t CTRL1_RST = ctrl1_t'(8'h00);

endpackage

// file: core/count_clock_select.sv
// Purpose: picks the counter advance tick from the clock sources
// Assumes: high and sub clock sources arrive as one-cycle enables on aclk
// Notes:   the event pin is asynchronous and goes through two flops
module count_clock_select
  import timer_core_pkg::*;
(
  input  logic     aclk,
  input  logic     aresetn,
  input  clk_sel_t clock_select_field,
  input  logic     high_clock_source,
  input  logic     sub_clock_source,
  input  logic     ext_count_clock_pin,
  output logic     count_tick
);

  localparam int unsigned SW = $clog2(SYS_DIV);
  localparam int unsigned HW = $clog2(HIGH_DIV_HI);
  localparam int unsigned LW = $clog2(HIGH_DIV_LO);

  logic [SW-1:0] sys_div_ff;
  logic [HW-1:0] high_div_ff;
  logic          ext_meta_ff;
  logic          ext_sync_ff;
  logic          ext_prev_ff;
  logic          ext_rise;
  logic          ext_fall;

  always_ff @(posedge aclk) begin
    if (!aresetn) sys_div_ff <= '0;
    else sys_div_ff <= sys_div_ff + SW'(1);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) high_div_ff <= '0;
    else if (high_clock_source) high_div_ff <= high_div_ff + HW'(1);
  end

  // edge detect reads only the second flop and its delayed copy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
    end else begin
      ext_meta_ff <= ext_count_clock_pin;
      ext_sync_ff <= ext_meta_ff;
      ext_prev_ff <= ext_sync_ff;
    end
  end

  assign ext_rise = ext_sync_ff & ~ext_prev_ff;
  assign ext_fall = ~ext_sync_ff & ext_prev_ff;

  always_comb begin
    case (clock_select_field)
      CK_SYS_DIV4:   count_tick = (sys_div_ff == SW'(SYS_DIV - 1));
      CK_SYS:        count_tick = 1'b1;
      CK_HIGH_DIV16: count_tick = high_clock_source &&
                                  (high_div_ff[LW-1:0] == LW'(HIGH_DIV_LO - 1));
      CK_HIGH_DIV64: count_tick = high_clock_source &&
                                  (high_div_ff == HW'(HIGH_DIV_HI - 1));
      CK_SUB_A,
      CK_SUB_B:      count_tick = sub_clock_source;
      CK_EXT_RISE:   count_tick = ext_rise;
      CK_EXT_FALL:   count_tick = ext_fall;
      default:       count_tick = 1'b0;
    endcase
  end

endmodule // count_clock_select

// file: core/output_pin_ctrl.sv
// Purpose: drives the timer output pin in compare and pwm modes
// Assumes: match pulses are single-cycle and on aclk
// Notes:   pwm phase is sampled one cycle after the period event
module output_pin_ctrl
  import timer_core_pkg::*;
(
  input  logic   aclk,
  input  logic   aresetn,
  input  ctrl1_t cfg,
  input  logic   run_rise,
  input  logic   cmp_hit,
  input  logic   period_hit,
  input  logic   duty_hit,
  output logic   timer_output_pin
);

  logic level_ff;
  logic phase_ff;
  logic nxt_level;

  // period start wins over duty end so a full-scale duty stays active
  always_ff @(posedge aclk) begin
    if (!aresetn) phase_ff <= 1'b0;
    else if (run_rise || period_hit) phase_ff <= 1'b1;
    else if (duty_hit) phase_ff <= 1'b0;
  end

  always_comb begin
    nxt_level = level_ff;
    case (cfg.mode)
      MODE_CMP: begin
        if (run_rise) nxt_level = cfg.oc;
        else if (cmp_hit) begin
          case (cfg.io)
            IO_LOW:    nxt_level = 1'b0;
            IO_HIGH:   nxt_level = 1'b1;
            IO_TOGGLE: nxt_level = ~level_ff;
            default:   nxt_level = level_ff;
          endcase
        end
      end
      MODE_PWM: begin
        case (cfg.io)
          PWM_INACTIVE: nxt_level = ~cfg.oc;
          PWM_ACTIVE:   nxt_level = cfg.oc;
          PWM_WAVE:     nxt_level = phase_ff ? cfg.oc : ~cfg.oc;
          default:      nxt_level = level_ff;
        endcase
      end
      default: nxt_level = level_ff;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_ff         <= 1'b0;
      timer_output_pin <= 1'b0;
    end else begin
      level_ff         <= nxt_level;
      timer_output_pin <= nxt_level ^ cfg.pol;
    end
  end

  toggle_out_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (cfg.mode == MODE_CMP && !run_rise && cmp_hit && cfg.io == IO_TOGGLE)
      |=> level_ff != $past(level_ff))
    else $error("compare toggle did not flip the output");

  pwm_start_a:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (cfg.mode == MODE_PWM && cfg.io == PWM_WAVE && period_hit)
      |=> ##1 timer_output_pin == (cfg.oc ^ cfg.pol))
    else $error("pwm period did not start the active phase");

endmodule // output_pin_ctrl

// file: core/compact_timer.sv
// Purpose: compact 16-bit timer with two comparators and one output pin
// Assumes: AXI4-Lite slave on aclk, register data in the low byte
// Notes:   software must keep the low/high byte access order
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
module compact_timer
  import timer_core_pkg::*;
(
  input  logic              aclk,
  input  logic              aresetn,
  input  logic [ADDR_W-1:0] awaddr,
  input  logic              awvalid,
  output logic              awready,
  input  logic [31:0]       wdata,
  input  logic [3:0]        wstrb,
  input  logic              wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  logic              bready,
  input  logic [ADDR_W-1:0] araddr,
  input  logic              arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  logic              rready,
  input  logic              high_clock_source,
  input  logic              sub_clock_source,
  input  logic              ext_count_clock_pin,
  output logic              timer_output_pin,
  output logic              match_a_irq,
  output logic              match_p_irq
);

  function automatic logic idx_mapped(input logic [3:0] idx);
    return idx <= IDX_STAT;
  endfunction

  ctrl0_t            ctrl0_ff;
  ctrl1_t            ctrl1_ff;
  logic [15:0]       count_ff;
  logic [15:0]       cmpa_ff;
  logic [7:0]        cmpp_ff;
  logic [7:0]        buf_ff;
  logic              run_prev_ff;
  logic              flag_a_ff;
  logic              flag_p_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic              aw_full_ff;
  logic [7:0]        w_data_ff;
  logic              w_lane0_ff;
  logic              w_full_ff;
  logic              count_tick;
  logic              run_rise;
  logic              advance;
  logic [15:0]       nxt_inc;
  logic              a_hit;
  logic              p_hit;
  logic              clr_on_a;
  logic              clr_hit;
  logic              do_wr;
  logic              wr_en;
  logic [3:0]        widx;
  logic              do_rd;
  logic [3:0]        ridx;
  logic [7:0]        rd_mux;

  count_clock_select u_clk (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .clock_select_field  (ctrl0_ff.clk_sel),
    .high_clock_source   (high_clock_source),
    .sub_clock_source    (sub_clock_source),
    .ext_count_clock_pin (ext_count_clock_pin),
    .count_tick          (count_tick)
  );

  output_pin_ctrl u_out (
    .aclk             (aclk),
    .aresetn          (aresetn),
    .cfg              (ctrl1_ff),
    .run_rise         (run_rise),
    .cmp_hit          (a_hit),
    .period_hit       (ctrl1_ff.dpx ? a_hit : p_hit),
    .duty_hit         (ctrl1_ff.dpx ? p_hit : a_hit),
    .timer_output_pin (timer_output_pin)
  );

  // ---- AXI4-Lite write side: address and data taken in either order
  assign awready = !aw_full_ff && !bvalid;
  assign wready  = !w_full_ff && !bvalid;
  assign do_wr   = aw_full_ff && w_full_ff && !bvalid;
  assign widx    = aw_addr_ff[5:2];
  assign wr_en   = do_wr && w_lane0_ff && idx_mapped(widx);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (awvalid && awready) begin
      aw_full_ff <= 1'b1;
      aw_addr_ff <= awaddr;
    end else if (do_wr) begin
      aw_full_ff <= 1'b0;
    end
  end

  // only byte lane 0 carries register data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_ff  <= 1'b0;
      w_data_ff  <= 8'h00;
      w_lane0_ff <= 1'b0;
    end else if (wvalid && wready) begin
      w_full_ff  <= 1'b1;
      w_data_ff  <= wdata[7:0];
      w_lane0_ff <= wstrb[0];
    end else if (do_wr) begin
      w_full_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid <= 1'b1;
      bresp  <= idx_mapped(widx) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ---- AXI4-Lite read side: one read outstanding, data registered
  assign arready = !rvalid;
  assign do_rd   = arvalid && arready;
  assign ridx    = araddr[5:2];

  always_comb begin
    case (ridx)
      IDX_CTRL0:   rd_mux = {ctrl0_ff, 3'h0};
      IDX_CTRL1:   rd_mux = ctrl1_ff;
      IDX_CNT_LO:  rd_mux = buf_ff;
      IDX_CNT_HI:  rd_mux = count_ff[15:8];
      IDX_CMPA_LO: rd_mux = buf_ff;
      IDX_CMPA_HI: rd_mux = cmpa_ff[15:8];
      IDX_CMPP:    rd_mux = cmpp_ff;
      IDX_STAT:    rd_mux = {6'h00, flag_p_ff, flag_a_ff};
      default:     rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (do_rd) begin
      rvalid <= 1'b1;
      rdata  <= {24'h00_0000, rd_mux};
      rresp  <= idx_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ---- control registers; mode changes are meant to happen with run low
  always_ff @(posedge aclk) begin
    if (!aresetn) ctrl0_ff <= CTRL0_RST;
    else if (wr_en && widx == IDX_CTRL0) ctrl0_ff <= ctrl0_t'(w_data_ff[7:3]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) ctrl1_ff <= CTRL1_RST;
    else if (wr_en && widx == IDX_CTRL1) ctrl1_ff <= ctrl1_t'(w_data_ff);
  end

  // ---- shared low-byte buffer: the write path wins a same-cycle clash
  always_ff @(posedge aclk) begin
    if (!aresetn) buf_ff <= BUF_RST;
    else if (wr_en && widx == IDX_CMPA_LO) buf_ff <= w_data_ff;
    else if (do_rd && ridx == IDX_CNT_HI) buf_ff <= count_ff[7:0];
    else if (do_rd && ridx == IDX_CMPA_HI) buf_ff <= cmpa_ff[7:0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) cmpa_ff <= CMPA_RST;
    else if (wr_en && widx == IDX_CMPA_HI) cmpa_ff <= {w_data_ff, buf_ff};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) cmpp_ff <= CMPP_RST;
    else if (wr_en && widx == IDX_CMPP) cmpp_ff <= w_data_ff;
  end

  // ---- counter and comparators
  assign run_rise = ctrl0_ff.run && !run_prev_ff;
  assign advance  = ctrl0_ff.run && !ctrl0_ff.pause && count_tick;
  assign nxt_inc  = count_ff + 16'h0001;
  assign a_hit    = advance && (nxt_inc == cmpa_ff);
  // a zero P value matches on the wrap to zero, which is overflow
  assign p_hit    = advance && (nxt_inc[15:8] == cmpp_ff) &&
                    (nxt_inc[7:0] == 8'h00);
  assign clr_on_a = (ctrl1_ff.mode == MODE_PWM) ? ctrl1_ff.dpx : ctrl1_ff.cclr;
  assign clr_hit  = clr_on_a ? a_hit : p_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn) run_prev_ff <= 1'b0;
    else run_prev_ff <= ctrl0_ff.run;
  end

  // no software path reaches the count except the run rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn) count_ff <= CNT_RST;
    else if (run_rise) count_ff <= CNT_RST;
    else if (advance) count_ff <= clr_hit ? CNT_RST : nxt_inc;
  end

  // ---- sticky match flags, write one to clear, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) flag_a_ff <= 1'b0;
    else if (a_hit) flag_a_ff <= 1'b1;
    else if (wr_en && widx == IDX_STAT && w_data_ff[STAT_A_BIT]) flag_a_ff <= 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) flag_p_ff <= 1'b0;
    else if (p_hit) flag_p_ff <= 1'b1;
    else if (wr_en && widx == IDX_STAT && w_data_ff[STAT_P_BIT]) flag_p_ff <= 1'b0;
  end

  assign match_a_irq = flag_a_ff;
  assign match_p_irq = flag_p_ff;

  // ---- checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  run_clear_a:
    assert property (run_rise |=> count_ff == CNT_RST)
    else $error("counter not cleared on run start");

  stop_hold_a:
    assert property (!ctrl0_ff.run |=> count_ff == $past(count_ff))
    else $error("counter moved while stopped");

  count_step_a:
    assert property (advance && !clr_hit && !run_rise
                     |=> count_ff == 16'($past(count_ff) + 16'h0001))
    else $error("counter did not advance by one");

  clear_match_a:
    assert property (advance && clr_hit && !run_rise |=> count_ff == CNT_RST)
    else $error("counter not cleared on selected match");

  flag_set_a:
    assert property ((a_hit |=> flag_a_ff) and (p_hit |=> flag_p_ff))
    else $error("match flag not set");

  flag_hold_a:
    assert property (flag_a_ff && !(wr_en && widx == IDX_STAT) |=> flag_a_ff)
    else $error("match flag dropped without software clear");

  pair_write_a:
    assert property (wr_en && widx == IDX_CMPA_HI
                     |=> cmpa_ff == {$past(w_data_ff), $past(buf_ff)})
    else $error("compare pair write did not merge buffer");

  pair_read_a:
    assert property (do_rd && ridx == IDX_CNT_HI && !(wr_en && widx == IDX_CMPA_LO)
                     |=> buf_ff == $past(count_ff[7:0]) && rdata[7:0] == $past(count_ff[15:8]))
    else $error("count high read did not capture low byte");

  p_upper_a:
    assert property (p_hit && clr_on_a && !a_hit && !run_rise
                     |=> count_ff == {$past(cmpp_ff), 8'h00})
    else $error("comparator P matched away from its upper byte");

  flag_p_hold_a:
    assert property (flag_p_ff && !(wr_en && widx == IDX_STAT) |=> flag_p_ff)
    else $error("P flag dropped without software clear");

  low_buffer_a:
    assert property (wr_en && widx == IDX_CMPA_LO
                     |=> buf_ff == $past(w_data_ff) && cmpa_ff == $past(cmpa_ff))
    else $error("compare low write reached more than the buffer");

  count_write_a:
    assert property (wr_en && (widx == IDX_CNT_LO || widx == IDX_CNT_HI) && !advance
                     && !run_rise |=> count_ff == $past(count_ff))
    else $error("register write changed the counter");

endmodule // compact_timer

// file: sim/event_partner.sv
// Purpose: far-side model, internal clock ticks and the event count pin
// Assumes: high and sub ticks are one-cycle enables on aclk
// Notes:   event pulses repeat every 160 ns, off the aclk edges on purpose
module event_partner (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ext_free,
  output logic      high_clock_source,
  output logic      sub_clock_source,
  output logic      ext_count_clock_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] sub_cnt_ff;

  // high tick every 2nd cycle, sub tick every 4th, so dividers show in the period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_clock_source <= 1'b0;
      sub_cnt_ff        <= 2'h0;
    end else begin
      high_clock_source <= ~high_clock_source;
      sub_cnt_ff        <= sub_cnt_ff + 2'h1;
    end
  end
  assign sub_clock_source = (sub_cnt_ff == 2'h3);

  // the pin is only ever driven from here, the device treats it as an input
  initial ext_count_clock_pin = 1'b0;

  task automatic pulse();
    #73 ext_count_clock_pin = 1'b1;
    #87 ext_count_clock_pin = 1'b0;
  endtask

  task automatic burst(input int n);
    repeat (n) pulse();
  endtask

  always begin
    wait (ext_free);
    pulse();
  end
endmodule // event_partner

// file: sim/tb_compact_timer.sv
// Purpose: self-checking bench for the compact timer core
// Assumes: AXI4-Lite master on aclk, event_partner at the pin side
// Notes:   results noted in queues, a negedge monitor compares them
module tb_compact_timer_core
  import timer_core_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [5:0] addr_c0 = {IDX_CTRL0, 2'b00};
  localparam logic [5:0] addr_c1 = {IDX_CTRL1, 2'b00};
  localparam logic [5:0] addr_dl = {IDX_CNT_LO, 2'b00};
  localparam logic [5:0] addr_dh = {IDX_CNT_HI, 2'b00};
  localparam logic [5:0] addr_al = {IDX_CMPA_LO, 2'b00};
  localparam logic [5:0] addr_ah = {IDX_CMPA_HI, 2'b00};
  localparam logic [5:0] addr_p  = {IDX_CMPP, 2'b00};
  localparam logic [5:0] addr_st = {IDX_STAT, 2'b00};

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic high_clock_source, sub_clock_source, ext_count_clock_pin;
  logic timer_output_pin, match_a_irq, match_p_irq;
  logic ext_free = 1'b0;
  logic [33:0] rq[$];
  logic [33:0] bq[$];
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  int seed;
  logic [7:0] lo, hi;
  int tick_div[8] = '{4, 1, 32, 128, 4, 4, 8, 8};
  logic [7:0] io_cfg[3] = '{8'h19, 8'h25, 8'h21};
  logic pin_init[3] = '{1'b1, 1'b1, 1'b0};
  logic pin_hit[3] = '{1'b0, 1'b0, 1'b1};

  always #10 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;

  // pins routed straight to the timer, no sharing logic in between
  compact_timer compact_timer_inst (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .high_clock_source(high_clock_source), .sub_clock_source(sub_clock_source),
    .ext_count_clock_pin(ext_count_clock_pin), .timer_output_pin(timer_output_pin),
    .match_a_irq(match_a_irq), .match_p_irq(match_p_irq));

  event_partner event_partner_inst (
    .aclk(aclk), .aresetn(aresetn), .ext_free(ext_free),
    .high_clock_source(high_clock_source), .sub_clock_source(sub_clock_source),
    .ext_count_clock_pin(ext_count_clock_pin));

  task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // sampled at negedge: handshakes seen here are taken at the next rising edge
  always @(negedge aclk) begin
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front(), "read data");
    if (bvalid && bready) chk({32'h0, bresp}, bq.pop_front(), "write response");
  end

  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic ta, tw, dn;
    dn = 1'b0;
    bq.push_back({32'h0, er});
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!dn) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      dn = bvalid;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (dn) bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [33:0] exp);
    logic ta, dn;
    dn = 1'b0;
    rq.push_back(exp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!dn) begin
      @(negedge aclk);
      ta = arvalid && arready;
      dn = rvalid;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (dn) rready <= 1'b0;
    end
  endtask

  task automatic wait_flag(input logic p, output int t);
    t = -1;
    for (int i = 0; i < 4000 && t < 0; i++) begin
      @(negedge aclk);
      if ((p ? match_p_irq : match_a_irq) === 1'b1) t = cyc;
    end
    if (t < 0) begin
      bad_count++;
      $display("ERROR %0t match flag never set", $time);
    end
  endtask

  // restart from a stopped counter so it begins at zero, then drop stale flags
  task automatic start(input logic [2:0] s);
    wr(addr_c0, {1'b0, s, 4'h0});
    wr(addr_c0, {1'b0, s, 4'h8});
    wr(addr_st, 8'h03);
  endtask

  task automatic measure(input logic p, input int ivl, input logic p1, input logic p2);
    int t0, t1;
    wait_flag(p, t0);
    repeat (2) @(negedge aclk);
    chk({33'h0, timer_output_pin}, {33'h0, p1}, "pin at match");
    wr(addr_st, 8'h03);
    wait_flag(p, t1);
    repeat (2) @(negedge aclk);
    chk({33'h0, timer_output_pin}, {33'h0, p2}, "pin at match");
    chk(34'(t1 - t0), 34'(ivl), "match interval");
    wr(addr_st, 8'h03);
  endtask

  task automatic summarize();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #(20 * 60000);
    bad_count++;
    $display("ERROR %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    seed = 32'ha64926cb;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 8; i++) rd(6'(i * 4), 34'h0);
    rd(6'h20, {RESP_SLVERR, 32'h0});
    wr(6'h3c, 8'h55, RESP_SLVERR);
    $display("test reset and map done");
    for (int i = 0; i < 3; i++) begin
      lo = 8'($random(seed));
      hi = 8'($random(seed));
      wr(addr_al, lo);
      wr(addr_ah, hi);
      rd(addr_ah, {26'h0, hi});
      rd(addr_al, {26'h0, lo});
    end
    $display("test byte pairing done");
    wr(addr_al, 8'h10);
    wr(addr_ah, 8'h00);
    wr(addr_c1, 8'h31);
    for (int s = 0; s < 8; s++) begin
      ext_free = (s >= 6);
      start(3'(s));
      measure(1'b0, 16 * tick_div[s], 1'b1, 1'b0);
    end
    ext_free = 1'b0;
    $display("test clock sources done");
    for (int i = 0; i < 3; i++) begin
      wr(addr_c1, io_cfg[i]);
      start(3'd1);
      repeat (2) @(negedge aclk);
      chk({33'h0, timer_output_pin}, {33'h0, pin_init[i]}, "pin after run");
      measure(1'b0, 16, pin_hit[i], pin_hit[i]);
    end
    $display("test output actions done");
    wr(addr_c1, 8'h00);
    wstrb <= 4'he;
    wr(addr_p, 8'h7f);
    wstrb <= 4'hf;
    rd(addr_p, 34'h00);
    wr(addr_p, 8'h01);
    rd(addr_p, 34'h01);
    start(3'd1);
    measure(1'b1, 256, 1'b0, 1'b0);
    $display("test comparator p done");
    wr(addr_c1, 8'hf1);
    wr(addr_al, 8'hff);
    wr(addr_ah, 8'hff);
    start(3'd6);
    event_partner_inst.burst(261);
    repeat (8) @(negedge aclk);
    rd(addr_dh, 34'h01);
    rd(addr_dl, 34'h05);
    wr(addr_c0, 8'he8);
    event_partner_inst.burst(3);
    repeat (8) @(negedge aclk);
    rd(addr_dh, 34'h01);
    rd(addr_dl, 34'h05);
    wr(addr_c0, 8'h60);
    wr(addr_dh, 8'h33);
    event_partner_inst.burst(3);
    repeat (8) @(negedge aclk);
    rd(addr_dh, 34'h01);
    rd(addr_dl, 34'h05);
    start(3'd7);
    event_partner_inst.burst(2);
    repeat (8) @(negedge aclk);
    rd(addr_dh, 34'h00);
    rd(addr_dl, 34'h02);
    $display("test event counting done");
    // no ticks while the pin is idle, so the mode change cannot race a period event
    wr(addr_c1, 8'ha8);
    wr(addr_al, 8'h40);
    wr(addr_ah, 8'h00);
    start(3'd1);
    repeat (2) @(negedge aclk);
    chk({33'h0, timer_output_pin}, 34'h1, "pwm active after run");
    measure(1'b0, 256, 1'b0, 1'b0);
    measure(1'b1, 256, 1'b1, 1'b1);
    $display("test pwm output done");
    summarize();
  end
endmodule // tb_compact_timer_core
